// >>> verilog/sar_adc_defs.vh
// constants of the converter control block
// assumes byte-wide registers on a plain strobe port
`ifndef SAR_ADC_DEFS_VH
`define SAR_ADC_DEFS_VH
`define ADR_CTRL0 3'h0
`define ADR_CTRL1 3'h1
`define ADR_CTRL2 3'h2
`define ADR_RES_HI 3'h3
`define ADR_RES_LO 3'h4
`define ADR_INTC 3'h5
`define CTRL0_START 7
`define CTRL0_BUSY 6
`define CTRL0_PWR 5
`define CTRL0_FMT 4
`define CTRL1_DIV_LSB 0
`define CTRL2_REF_LSB 0
`define INTC_GIE 0
`define INTC_CIE 1
`define INTC_FLAG 2
`define CTRL0_RST 8'h00
`define CTRL1_RST 8'h00
`define CTRL2_RST 8'h00
`define SAMPLE_CYC 5'h04
`define CONVERT_CYC 5'h0C
`define TOTAL_CYC 5'h10
`endif

// >>> verilog/conv_clock_div.v
// converter clock tick generator, divides sys clock by 2^div
// assumes divider setting is stable while the converter runs
`timescale 1ns/1ns
module conv_clock_div (
  input wire sys_clk,
  input wire nrst,
  input wire run,
  input wire [2:0] div,
  output reg tick
);
  reg [6:0] count;
  wire [6:0] last = (7'h01 << div) - 7'h01;
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      count <= 7'h00;
      tick <= 1'b0;
    end else if (!run) begin
      count <= 7'h00;
      tick <= 1'b0;
    end else if (count >= last) begin
      count <= 7'h00;
      tick <= 1'b1;
    end else begin
      count <= count + 7'h01;
      tick <= 1'b0;
    end
  end
endmodule

// >>> verilog/sar_adc_conversion_control.v
// control of a 12-bit successive approximation converter
// assumes the analog core samples and returns bits on its own pins
// Summary of operation
// - sample for 4 converter clocks, then convert for 12.
// - a whole conversion takes exactly 16 converter clocks.
// - once started, the conversion finishes with no software help.
// - converter clock is sys clock divided by 1 up to 128.
// - source 0000, 0100 or 11xx takes the chosen pin channel.
// - internal sources disconnect the pin channel automatically.
// - one format bit chooses result alignment in the two bytes.
// - start bit low-high-low; high resets, falling edge launches.
// - busy flag sets as soon as a conversion starts.
// - busy stays high until completion; result then readable.
// - completion sets request flag; interrupt raised when enabled.
// - power enable low shuts the converter fully off.
// - result is unsigned 12-bit, full scale FFF.
`timescale 1ns/1ns
`include "sar_adc_defs.vh"
module sar_adc_conversion_control (
  input wire sys_clk,
  input wire nrst,
  input wire [2:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  input wire comparator,
  output reg analog_power,
  output reg sample_hold,
  output reg [11:0] dac_code,
  output reg pin_connect,
  output reg [3:0] pin_channel,
  output reg [3:0] source_select,
  output reg [1:0] reference_select,
  output reg irq
);
  localparam ST_IDLE = 2'h0;
  localparam ST_ARMED = 2'h1;
  localparam ST_SAMPLE = 2'h2;
  localparam ST_CONVERT = 2'h3;

  // true when the source code routes an external pin
  function is_pin_source;
    input [3:0] src;
    begin
      is_pin_source = (src == 4'h0) || (src == 4'h4) ||
        (src[3:2] == 2'h3);
    end
  endfunction

  // one-hot trial bit, msb first; used for the code shown and its next
  function [11:0] bit_mask;
    input [3:0] idx;
    begin
      bit_mask = 12'h800 >> idx;
    end
  endfunction

  // one result byte in the chosen alignment
  function [7:0] result_byte;
    input [11:0] r;
    input fmt;
    input high;
    begin
      if (high) begin
        result_byte = fmt ? {4'h0, r[11:8]} : r[11:4];
      end else begin
        result_byte = fmt ? r[7:0] : {r[3:0], 4'h0};
      end
    end
  endfunction

  reg start_bit;
  reg converter_power_enable;
  reg result_format_select;
  reg [3:0] pin_channel_select;
  reg [3:0] input_source_select;
  reg [2:0] conv_clock_divider;
  reg [1:0] reference_source_select;
  reg [3:0] amp_setting;
  reg global_interrupt_enable;
  reg converter_interrupt_enable;
  reg converter_interrupt_flag;
  reg conversion_busy_flag;
  reg [1:0] state;
  reg [4:0] phase_count;
  reg [3:0] bit_index;
  reg [11:0] approx;
  reg [11:0] result;
  wire tick;
  wire done;
  wire [11:0] trial;
  wire [11:0] kept;
  reg [7:0] next_rdata;
  reg [1:0] next_state;
  reg [4:0] next_phase_count;
  reg [3:0] next_bit_index;
  reg [11:0] next_approx;
  reg [11:0] next_result;
  reg next_busy;
  reg next_sample_hold;
  reg [11:0] next_dac_code;

  // divider idles when the converter is unpowered or idle
  conv_clock_div u_div (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .run(converter_power_enable && state[1]),
    .div(conv_clock_divider),
    .tick(tick)
  );

  assign done = (state == ST_CONVERT) && tick &&
    (phase_count == `CONVERT_CYC - 5'h01);
  assign trial = approx | bit_mask(bit_index);
  assign kept = comparator ? trial : approx;

  // register writes; start launches on its falling edge
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      start_bit <= 1'b0;
      converter_power_enable <= 1'b0;
      result_format_select <= 1'b0;
      pin_channel_select <= 4'h0;
      input_source_select <= 4'h0;
      conv_clock_divider <= 3'h0;
      reference_source_select <= 2'h0;
      amp_setting <= 4'h0;
      global_interrupt_enable <= 1'b0;
      converter_interrupt_enable <= 1'b0;
    end else if (wr) begin
      case (addr)
        `ADR_CTRL0: begin
          start_bit <= wdata[`CTRL0_START];
          converter_power_enable <= wdata[`CTRL0_PWR];
          result_format_select <= wdata[`CTRL0_FMT];
          pin_channel_select <= wdata[3:0];
        end
        `ADR_CTRL1: begin
          input_source_select <= wdata[7:4];
          conv_clock_divider <= wdata[`CTRL1_DIV_LSB +: 3];
        end
        `ADR_CTRL2: begin
          reference_source_select <= wdata[`CTRL2_REF_LSB +: 2];
          amp_setting <= wdata[7:4];
        end
        `ADR_INTC: begin
          global_interrupt_enable <= wdata[`INTC_GIE];
          converter_interrupt_enable <= wdata[`INTC_CIE];
        end
        default: begin
        end
      endcase
    end
  end

  // next state of the conversion sequencer
  always @* begin
    next_state = state;
    next_phase_count = phase_count;
    next_bit_index = bit_index;
    next_approx = approx;
    next_result = result;
    next_busy = conversion_busy_flag;
    if (!converter_power_enable) begin
      // power off aborts with no result and no flag
      next_state = ST_IDLE;
      next_busy = 1'b0;
    end else if (start_bit) begin
      // high level holds the converter in reset
      next_state = ST_ARMED;
      next_busy = 1'b0;
      next_phase_count = 5'h00;
    end else begin
      case (state)
        ST_IDLE: begin
          next_state = ST_IDLE;
        end
        ST_ARMED: begin
          next_state = ST_SAMPLE;
          next_busy = 1'b1;
          next_phase_count = 5'h00;
        end
        ST_SAMPLE: begin
          if (tick && phase_count == `SAMPLE_CYC - 5'h01) begin
            next_state = ST_CONVERT;
            next_phase_count = 5'h00;
            next_bit_index = 4'h0;
            next_approx = 12'h000;
          end else if (tick) begin
            next_phase_count = phase_count + 5'h01;
          end
        end
        ST_CONVERT: begin
          // one decision per converter clock, msb first
          if (tick) begin
            next_approx = kept;
            next_bit_index = bit_index + 4'h1;
            next_phase_count = phase_count + 5'h01;
          end
          if (done) begin
            // 4 + 12 ticks
            next_result = kept;
            next_state = ST_IDLE;
            next_busy = 1'b0;
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
    // code from next values: a copy one clock late would judge old trials
    next_sample_hold = (next_state == ST_SAMPLE);
    next_dac_code = (next_state == ST_CONVERT) ?
      (next_approx | bit_mask(next_bit_index)) : 12'h000;
  end

  // sequencer registers; code and phase flag move with the state
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      phase_count <= 5'h00;
      bit_index <= 4'h0;
      approx <= 12'h000;
      result <= 12'h000;
      conversion_busy_flag <= 1'b0;
      sample_hold <= 1'b0;
      dac_code <= 12'h000;
    end else begin
      state <= next_state;
      phase_count <= next_phase_count;
      bit_index <= next_bit_index;
      approx <= next_approx;
      result <= next_result;
      conversion_busy_flag <= next_busy;
      sample_hold <= next_sample_hold;
      dac_code <= next_dac_code;
    end
  end

  // flag set wins over a software clear in the same cycle
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      converter_interrupt_flag <= 1'b0;
    end else if (done && !start_bit && converter_power_enable) begin
      converter_interrupt_flag <= 1'b1;
    end else if (wr && addr == `ADR_INTC) begin
      converter_interrupt_flag <= wdata[`INTC_FLAG];
    end
  end

  // read mux; alignment by format bit
  always @* begin
    next_rdata = 8'h00;
    case (addr)
      `ADR_CTRL0: next_rdata = {start_bit, conversion_busy_flag,
        converter_power_enable, result_format_select,
        pin_channel_select};
      `ADR_CTRL1: next_rdata = {input_source_select, 1'b0,
        conv_clock_divider};
      `ADR_CTRL2: next_rdata = {amp_setting, 2'h0,
        reference_source_select};
      // unsigned code
      `ADR_RES_HI: next_rdata = result_byte(result,
        result_format_select, 1'b1);
      `ADR_RES_LO: next_rdata = result_byte(result,
        result_format_select, 1'b0);
      `ADR_INTC: next_rdata = {5'h00, converter_interrupt_flag,
        converter_interrupt_enable, global_interrupt_enable};
      default: next_rdata = 8'h00;
    endcase
  end

  // outputs registered
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 8'h00;
      analog_power <= 1'b0;
      pin_connect <= 1'b0;
      pin_channel <= 4'h0;
      source_select <= 4'h0;
      reference_select <= 2'h0;
      irq <= 1'b0;
    end else begin
      rdata <= rd ? next_rdata : 8'h00;
      analog_power <= converter_power_enable;
      // internal sources drop the pin path
      pin_connect <= converter_power_enable &&
        is_pin_source(input_source_select);
      pin_channel <= pin_channel_select;
      source_select <= input_source_select;
      reference_select <= reference_source_select;
      irq <= converter_interrupt_flag && global_interrupt_enable &&
        converter_interrupt_enable;
    end
  end
endmodule

// >>> verification/sar_adc_chk.sv
// checker of converter control ports
// assumes bind from the bench top, one clock domain
`timescale 1ns/1ns
module sar_adc_chk (
  input wire sys_clk,
  input wire nrst,
  input wire rd,
  input wire [7:0] rdata,
  input wire analog_power,
  input wire sample_hold,
  input wire [11:0] dac_code,
  input wire pin_connect,
  input wire [3:0] source_select
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_pin_connect: assert property (
    pin_connect == (analog_power && (source_select == 4'h0 ||
    source_select == 4'h4 || source_select[3:2] == 2'h3)))
    else $error("pin connect mismatch");
  a_rdata_idle: assert property (
    !$past(rd) |-> rdata == 8'h00) else $error("rdata not idle");
  a_sample_len: assert property (
    $rose(sample_hold) |-> sample_hold[*4]) else $error("sample short");
  a_convert_len: assert property (
    $fell(sample_hold) && analog_power |-> ##1 (dac_code != 12'h000)[*8])
    else $error("convert short");
  a_first_trial: assert property (
    $fell(sample_hold) && analog_power |-> ##[0:1] dac_code == 12'h800)
    else $error("first trial wrong");
  a_code_after: assert property (
    $rose(dac_code != 12'h000) |-> $past(sample_hold) ||
    $past(sample_hold, 2)) else $error("convert without sample");
  a_power_off: assert property (
    !analog_power && !$past(analog_power) |-> !sample_hold &&
    dac_code == 12'h000) else $error("active while off");
  a_sample_code: assert property (
    sample_hold |-> dac_code == 12'h000) else $error("code in sample");
endmodule

// >>> verification/sar_analog_model.sv
// ideal analog core: comparator against a held input level
// assumes the trial code settles within one clock
`timescale 1ns/1ns
module sar_analog_model (
  input wire [11:0] dac_code,
  input wire [11:0] level,
  output wire comparator
);
  // pin already in analog function; no offset or noise
  assign comparator = (level >= dac_code);
endmodule

// >>> verification/sar_adc_conversion_control_tb_top.sv
// self-checking bench of the converter control
// assumes ideal analog model and the strobe register port
`timescale 1ns/1ns
module sar_adc_conversion_control_tb_top;
  logic sys_clk = 0, nrst = 0, wr = 0, rd = 0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00, d;
  logic [11:0] level = 12'h000;
  logic [31:0] seed = 32'hB57D;
  wire [7:0] rdata;
  wire [11:0] dac_code;
  wire [3:0] pin_channel, source_select;
  wire [1:0] reference_select;
  wire comparator, analog_power, sample_hold, pin_connect, irq;
  int n_fail = 0, samples_checked = 0, i;
  always #2 sys_clk = ~sys_clk;
  sar_adc_conversion_control dut_u (.sys_clk(sys_clk), .nrst(nrst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .comparator(comparator), .analog_power(analog_power),
    .sample_hold(sample_hold), .dac_code(dac_code),
    .pin_connect(pin_connect), .pin_channel(pin_channel),
    .source_select(source_select), .reference_select(reference_select),
    .irq(irq));
  sar_analog_model ana_u (.dac_code(dac_code), .level(level),
    .comparator(comparator));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [2:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    addr <= a;
    wdata <= v;
    wr <= 1;
    @(posedge sys_clk);
    wr <= 0;
  endtask
  task automatic rreg(input logic [2:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1;
    @(posedge sys_clk);
    rd <= 0;
    #1 v = rdata;
  endtask
  task automatic conv(input logic [11:0] v, input logic [2:0] dv,
    input logic f, input logic [3:0] src, input logic [3:0] ch,
    input logic ie);
    logic [7:0] b, lo, hi;
    logic pc;
    int n;
    pc = src == 4'h0 || src == 4'h4 || src[3:2] == 2'h3;
    level <= v;
    wreg(5, 8'h00);
    wreg(5, {6'h00, ie, ie});
    wreg(1, {src, 1'b0, dv});
    wreg(2, {ch, 2'h0, dv[1:0]});
    wreg(0, {3'h5, f, ch});
    wreg(0, {3'h1, f, ch});
    @(posedge sys_clk);
    rreg(0, b);
    chk(b[6], 1);
    chk({pin_connect, pin_channel}, {pc, ch});
    chk({source_select, reference_select}, {src, dv[1:0]});
    for (n = 0; n < 300 && b[6]; n++) rreg(0, b);
    chk(b[6], 0);
    rreg(4, lo);
    rreg(3, hi);
    chk({hi, lo}, f ? {4'h0, v} : {v, 4'h0});
    rreg(5, b);
    chk(b[2], 1);
    chk(irq, ie);
    rreg(3, b);
    chk(b, hi);
    $display("conv %h div %0d fmt %0d done", v, dv, f);
  endtask
  task automatic summarize;
    $display("checks %0d fails %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    summarize;
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    nrst <= 1;
    rreg(0, d);
    chk(d, 0);
    wreg(6, 8'hFF);
    rreg(6, d);
    chk(d, 0);
    $display("register reset test done");
    conv(12'hFFF, 3'h2, 0, 4'h0, 4'h9, 1);
    conv(12'h000, 3'h1, 1, 4'h5, 4'h3, 0);
    for (i = 0; i < 16; i++) begin
      seed = xs(seed);
      conv(seed[11:0], {2'h0, seed[12]}, seed[13], i[3:0], seed[19:16],
        seed[20]);
    end
    wreg(0, 8'h80);
    wreg(0, 8'h00);
    repeat (2) @(posedge sys_clk);
    chk(analog_power, 0);
    rreg(0, d);
    chk(d[6], 0);
    $display("power off test done");
    summarize;
  end
endmodule
bind sar_adc_conversion_control sar_adc_chk chk_u (.sys_clk(sys_clk),
  .nrst(nrst), .rd(rd), .rdata(rdata), .analog_power(analog_power),
  .sample_hold(sample_hold), .dac_code(dac_code),
  .pin_connect(pin_connect), .source_select(source_select));
